/* verif/test_two_wire_eeprom_slave.sv */
// Self-checking bench for the two-wire serial memory target.
module test_two_wire_eeprom_slave;
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;

  localparam logic [2:0] STRAP = 3'h5;
  logic       mclk;
  logic       lclk;
  logic       rst;
  logic       ce;
  logic       wp;
  logic       dev_oe_n;
  logic       dev_out;
  logic       standby;
  logic       busy;
  tw_state_t  st;
  wire        scl;
  wire        host_oe_n;
  wire        sda;
  int         err_total;
  int         num_checks;
  logic       a;
  logic [7:0] d;

  // Pulled-up wire: low whenever either party pulls it.
  assign sda = (dev_oe_n === 1'b0 || host_oe_n === 1'b0) ? 1'b0 : 1'b1;

  tw_eeprom_slave #(.PROG_CYCLES(2000)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda), .sda_out(dev_out),
    .sda_oe_n(dev_oe_n), .chip_select_strap_high(STRAP[2]),
    .chip_select_strap_mid(STRAP[1]), .chip_select_strap_low(STRAP[0]),
    .write_protect(wp), .standby(standby), .program_busy(busy), .link_state(st));

  tw_host_model host (.lclk(lclk), .sda(sda), .scl(scl), .oe_n(host_oe_n));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task test_done();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Transfer helpers
  // ---------------------------------------------------------------------------
  task dev_word(input logic rw, input logic exp_ack);
    host.start();
    host.wr_byte({4'hA, STRAP, rw}, a);
    chk("device word ack", {7'h00, exp_ack}, {7'h00, a});
  endtask

  task wr_data(input logic [7:0] b);
    host.wr_byte(b, a);
    chk("byte ack", 8'h01, {7'h00, a});
  endtask

  task set_addr(input logic [15:0] adr);
    dev_word(1'b0, 1'b1);
    wr_data(adr[15:8]);
    wr_data(adr[7:0]);
  endtask

  task read_at(input logic [15:0] adr, input logic [7:0] exp, input logic more);
    set_addr(adr);
    dev_word(1'b1, 1'b1);
    host.rd_byte(more, d);
    chk("read byte", exp, d);
  endtask

  // A program cycle that never ends would hang the bench, so the wait is bounded.
  task wait_done();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 5000) begin
      chk("program cycle end", 8'h00, 8'h01);
      test_done();
    end else begin
      repeat (3) @(posedge mclk);
      chk("standby after program", 8'h01, {7'h00, standby});
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_write_read();
    set_addr(16'h0123);
    wr_data(8'h5A);
    host.stop();
    repeat (20) @(posedge mclk);
    chk("busy after stop", 8'h01, {7'h00, busy});
    dev_word(1'b0, 1'b0);
    host.stop();
    wait_done();
    read_at(16'h0123, 8'h5A, 1'b0);
    host.stop();
    repeat (4) @(posedge mclk);
    chk("standby after read", 8'h01, {7'h00, standby});
    $display("test write_read done");
  endtask

  task t_page();
    set_addr(16'h003E);
    wr_data(8'h11);
    wr_data(8'h22);
    wr_data(8'h33);
    host.stop();
    // With the clock enable low the program timer must not advance at all.
    @(posedge mclk);
    ce <= 1'b0;
    repeat (2500) @(posedge mclk);
    chk("busy frozen by clock enable", 8'h01, {7'h00, busy});
    ce <= 1'b1;
    wait_done();
    read_at(16'h003E, 8'h11, 1'b0);
    host.stop();
    dev_word(1'b1, 1'b1);
    host.rd_byte(1'b0, d);
    chk("current address byte", 8'h22, d);
    host.stop();
    read_at(16'h0000, 8'h33, 1'b0);
    host.stop();
    $display("test page done");
  endtask

  task t_wrap();
    set_addr(16'hFFFF);
    wr_data(8'h77);
    host.stop();
    wait_done();
    read_at(16'h7FFF, 8'h77, 1'b1);
    host.rd_byte(1'b0, d);
    chk("wrapped sequential byte", 8'h33, d);
    host.stop();
    $display("test wrap done");
  endtask

  task t_refuse();
    host.start();
    host.wr_byte({4'hA, STRAP ^ 3'h4, 1'b1}, a);
    chk("strap mismatch ack", 8'h00, {7'h00, a});
    host.start();
    host.wr_byte({4'h5, STRAP, 1'b1}, a);
    chk("code mismatch ack", 8'h00, {7'h00, a});
    chk("state after mismatch", 8'(TW_IDLE), 8'(st));
    host.stop();
    $display("test refuse done");
  endtask

  task t_protect();
    @(posedge mclk);
    wp <= 1'b1;
    repeat (4) @(posedge mclk);
    set_addr(16'h0123);
    wr_data(8'hC3);
    host.stop();
    repeat (20) @(posedge mclk);
    chk("busy under protect", 8'h00, {7'h00, busy});
    wp <= 1'b0;
    repeat (4) @(posedge mclk);
    read_at(16'h0123, 8'h5A, 1'b0);
    host.stop();
    $display("test protect done");
  endtask

  task t_recover();
    // Interrupt a read while the target holds the line low on a zero bit.
    set_addr(16'h0123);
    dev_word(1'b1, 1'b1);
    host.clk_bit(1'b1, a);
    host.clk_bit(1'b1, a);
    repeat (4) @(posedge mclk);
    chk("line held by target", 8'h00, {7'h00, sda});
    chk("data drive value", 8'h00, {7'h00, dev_out});
    host.start();
    repeat (9) host.clk_bit(1'b1, a);
    host.start();
    host.stop();
    repeat (4) @(posedge mclk);
    chk("standby after recovery", 8'h01, {7'h00, standby});
    read_at(16'h0123, 8'h5A, 1'b0);
    host.stop();
    $display("test recover done");
  endtask

  initial begin
    #1000000;
    chk("run time limit", 8'h00, 8'h01);
    test_done();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("standby at reset", 8'h01, {7'h00, standby});
    t_write_read();
    t_page();
    t_wrap();
    t_refuse();
    t_protect();
    t_recover();
    test_done();
  end
endmodule

/* verif/tw_host_model.sv */
// Bus host model: makes the serial clock and pulls the open-drain data line.
module tw_host_model (
  input  wire logic lclk, // Host timing clock, 15 ns.
  input  wire logic sda,  // Resolved level of the data wire.
  output logic      scl,  // Serial clock, still between frames.
  output logic      oe_n  // Low while the host pulls the data line low.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl  = 1'b1;
    oe_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask

  // ---------------------------------------------------------------------------
  // Bus conditions
  // ---------------------------------------------------------------------------
  // Each phase lasts 8 ticks (120 ns), above the 100 ns the target needs.
  task automatic start();
    tick(1);
    oe_n <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    oe_n <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask

  task automatic stop();
    tick(1);
    oe_n <= 1'b0;
    tick(8);
    scl <= 1'b1;
    tick(8);
    oe_n <= 1'b1;
    tick(8);
  endtask

  // ---------------------------------------------------------------------------
  // Bit and byte transfers
  // ---------------------------------------------------------------------------
  // Data moves only while the clock is low; the wire is sampled mid-high.
  task automatic clk_bit(input logic b, output logic got);
    tick(1);
    oe_n <= b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    got = sda;
    tick(4);
    scl <= 1'b0;
    tick(3);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], x);
    end
    clk_bit(1'b1, x);
    ack = ~x;
  endtask

  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~more, x);
  endtask
endmodule

/* verilog/tw_consts.svh */
// Constants of the two-wire serial memory target: fields, counts and timing.
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

// ----------------------------------------------------------------------------
// Device address word layout
// ----------------------------------------------------------------------------
`define TW_DEV_CODE     4'hA
`define TW_DA_CODE      7:4
`define TW_DA_SEL       3:1
`define TW_DA_RW        0
`define TW_BYTE_MSB     7

// ----------------------------------------------------------------------------
// Bit counter values within one nine-clock byte slot
// ----------------------------------------------------------------------------
`define TW_CNT_ZERO     4'h0
`define TW_CNT_ONE      4'h1
`define TW_CNT_ACK      4'h8
`define TW_CNT_END      4'h9

// ----------------------------------------------------------------------------
// Memory shape and timing
// ----------------------------------------------------------------------------
`define TW_ADDR_BITS    15
`define TW_PAGE_BITS    6
`define TW_PROG_TIME_US 5000
`define TW_MCLK_MHZ     100

`endif

/* verilog/tw_eeprom_slave.sv */
// Two-wire serial memory target: bus protocol, page buffer, program timer, array.
`include "tw_consts.svh"

module tw_eeprom_slave #(
  parameter int ADDR_W      = `TW_ADDR_BITS,
  parameter int PAGE_W      = `TW_PAGE_BITS,
  parameter int PROG_CYCLES = `TW_PROG_TIME_US * `TW_MCLK_MHZ
) (
  input  wire logic          mclk,                   // System clock, 100 MHz.
  input  wire logic          rst,                    // Asynchronous reset, active high.
  input  wire logic          ce,                     // Clock enable for the mclk logic.
  input  wire logic          scl,                    // Serial clock from the host.
  input  wire logic          sda_in,                 // Serial data line level.
  output logic               sda_out,                // Serial data drive value, always low.
  output logic               sda_oe_n,               // Low while the data line is pulled low.
  input  wire logic          chip_select_strap_high, // Address strap, top bit.
  input  wire logic          chip_select_strap_mid,  // Address strap, middle bit.
  input  wire logic          chip_select_strap_low,  // Address strap, low bit.
  input  wire logic          write_protect,          // High blocks programming.
  output logic               standby,                // Idle with no program cycle.
  output logic               program_busy,           // Self-timed program cycle running.
  output tw_pkg::tw_state_t  link_state              // Protocol state.
);
  import tw_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGES = 1 << PAGE_W;
  localparam int HI_W  = ADDR_W - 8;
  localparam int TMR_W = $clog2(PROG_CYCLES);

  // --------------------------------------------------------------------------
  // Link clock domain
  // --------------------------------------------------------------------------
  // Each rising serial clock captures one data bit and toggles a flag. The
  // captured bit stays put until the next rise, far longer than the crossing.
  logic bit_cap;
  logic bit_tgl;

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      bit_cap <= 1'b0;
      bit_tgl <= 1'b0;
    end else begin
      bit_cap <= sda_in;
      bit_tgl <= ~bit_tgl;
    end
  end

  // --------------------------------------------------------------------------
  // Synchronisers into mclk
  // --------------------------------------------------------------------------
  logic       scl_m, scl_s, scl_d;
  logic       sda_m, sda_s, sda_d;
  logic       tgl_m, tgl_s, tgl_d;
  logic [2:0] strap_m, strap_s;
  logic       wp_m, wp_s;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {tgl_m, tgl_s, tgl_d} <= 3'h0;
      strap_m               <= 3'h0;
      strap_s               <= 3'h0;
      wp_m                  <= 1'b0;
      wp_s                  <= 1'b0;
    end else if (ce) begin
      {scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {tgl_m, tgl_s, tgl_d} <= {bit_tgl, tgl_m, tgl_s};
      strap_m <= {chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low};
      strap_s <= strap_m;
      wp_m    <= write_protect;
      wp_s    <= wp_m;
    end
  end

  // --------------------------------------------------------------------------
  // Bus events and decode
  // --------------------------------------------------------------------------
  tw_state_t         state;
  logic [3:0]        cnt;
  logic [7:0]        sreg;
  logic              host_ack_n;
  logic              rd_first;
  logic [7:0]        txbuf;
  logic [ADDR_W-1:0] ctr;
  logic [HI_W-1:0]   addr_hi;
  logic [7:0]        pg_data [PAGES];
  logic [PAGES-1:0]  pg_mask;
  logic              busy;
  logic [TMR_W-1:0]  tmr;
  logic [PAGE_W-1:0] ci;
  logic              ci_done;
  logic [7:0]        mem [DEPTH];

  wire start_evt = scl_s && scl_d && sda_d && !sda_s;
  wire stop_evt  = scl_s && scl_d && !sda_d && sda_s;
  wire fall_evt  = scl_d && !scl_s;
  wire rise_evt  = tgl_s ^ tgl_d;
  wire ack_slot  = fall_evt && (cnt == `TW_CNT_ACK);
  wire byte_end  = fall_evt && (cnt == `TW_CNT_END);

  wire dev_match = (sreg[`TW_DA_CODE] == `TW_DEV_CODE)
                && (sreg[`TW_DA_SEL] == strap_s);
  wire dev_ok    = dev_match && !busy;
  wire dev_rd    = sreg[`TW_DA_RW];
  wire rx_data   = (state == TW_WHI) || (state == TW_WLO) || (state == TW_WDATA);
  wire give_ack  = ((state == TW_DEV) && dev_ok) || rx_data;
  wire wr_byte   = ack_slot && (state == TW_WDATA);
  wire rd_go     = byte_end && (state == TW_RD) && (rd_first || !host_ack_n);
  wire rd_stop   = byte_end && (state == TW_RD) && !rd_first && host_ack_n;
  wire tx_slot   = fall_evt && (state == TW_RD) && (cnt != `TW_CNT_ZERO);
  wire tx_bit    = txbuf[~cnt[2:0]];
  wire [7:0] rd_byte = mem[ctr];
  wire [ADDR_W-PAGE_W-1:0] page_sel = ctr[ADDR_W-1:PAGE_W];
  wire prog_start = stop_evt && (state == TW_WDATA) && (|pg_mask) && !wp_s;
  wire commit_en  = busy && !ci_done;

  // --------------------------------------------------------------------------
  // Bit counter and receive shifter
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt        <= `TW_CNT_ZERO;
      sreg       <= 8'h00;
      host_ack_n <= 1'b1;
    end else if (ce) begin
      if (start_evt || byte_end) begin
        cnt <= `TW_CNT_ZERO;
      end else if (rise_evt && (cnt != `TW_CNT_END)) begin
        cnt <= cnt + `TW_CNT_ONE;
        if (cnt < `TW_CNT_ACK) begin
          sreg <= {sreg[6:0], bit_cap};
        end else begin
          host_ack_n <= bit_cap;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state    <= TW_IDLE;
      rd_first <= 1'b0;
    end else if (ce) begin
      if (start_evt) begin
        state    <= TW_DEV;
        rd_first <= 1'b0;
      end else if (stop_evt) begin
        state <= TW_IDLE;
      end else if (ack_slot) begin
        case (state)
          TW_DEV: begin
            if (dev_ok) begin
              state    <= dev_rd ? TW_RD : TW_WHI;
              rd_first <= dev_rd;
            end else begin
              state <= TW_IDLE;
            end
          end
          TW_WHI:  state <= TW_WLO;
          TW_WLO:  state <= TW_WDATA;
          default: state <= state;
        endcase
      end else if (rd_stop) begin
        state <= TW_IDLE;
      end else if (rd_go) begin
        rd_first <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Address counter, read buffer and page buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctr     <= '0;
      addr_hi <= '0;
      txbuf   <= 8'h00;
      pg_mask <= '0;
    end else if (ce) begin
      if (ack_slot && (state == TW_WHI)) begin
        addr_hi <= sreg[HI_W-1:0];
      end
      if (ack_slot && (state == TW_WLO)) begin
        ctr <= {addr_hi, sreg};
      end
      if (ack_slot && (state == TW_DEV)) begin
        pg_mask <= '0;
      end
      if (wr_byte) begin
        pg_mask[ctr[PAGE_W-1:0]] <= 1'b1;
        ctr[PAGE_W-1:0]          <= ctr[PAGE_W-1:0] + 1'b1;
      end
      if (rd_go) begin
        txbuf <= rd_byte;
        ctr   <= ctr + 1'b1;
      end
    end
  end

  // Page data has no reset; only entries flagged in pg_mask are ever used.
  always_ff @(posedge mclk) begin
    if (ce && wr_byte) begin
      pg_data[ctr[PAGE_W-1:0]] <= sreg;
    end
  end

  // --------------------------------------------------------------------------
  // Data line drive
  // --------------------------------------------------------------------------
  // Every change waits for a seen falling clock, so the line only moves while
  // the clock is low; start and stop only ever release it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
      if (start_evt || stop_evt) begin
        sda_oe_n <= 1'b1;
      end else if (ack_slot) begin
        sda_oe_n <= !give_ack;
      end else if (byte_end) begin
        sda_oe_n <= rd_go ? rd_byte[`TW_BYTE_MSB] : 1'b1;
      end else if (tx_slot) begin
        sda_oe_n <= tx_bit;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Self-timed program cycle
  // --------------------------------------------------------------------------
  // The page is copied one entry per cycle at the start of the cycle, so the
  // timer must be longer than one page; the array is then silent until done.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy    <= 1'b0;
      tmr     <= '0;
      ci      <= '0;
      ci_done <= 1'b1;
    end else if (ce) begin
      if (prog_start) begin
        busy    <= 1'b1;
        tmr     <= TMR_W'(PROG_CYCLES - 1);
        ci      <= '0;
        ci_done <= 1'b0;
      end else if (busy) begin
        tmr <= tmr - 1'b1;
        ci  <= ci + 1'b1;
        if (&ci) begin
          ci_done <= 1'b1;
        end
        if (tmr == '0) begin
          busy <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && commit_en && pg_mask[ci]) begin
      mem[{page_sel, ci}] <= pg_data[ci];
    end
  end

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      standby      <= 1'b1;
      program_busy <= 1'b0;
      link_state   <= TW_IDLE;
    end else if (ce) begin
      standby      <= (state == TW_IDLE) && !busy;
      program_busy <= busy;
      link_state   <= state;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_dev_slot;
    ce && ack_slot && (state == TW_DEV);
  endsequence

  sequence s_page_byte;
    ce && wr_byte;
  endsequence

  a_ack_on_match: assert property (s_dev_slot and (dev_ok) |=> !sda_oe_n)
    else $error("matching device word not acknowledged");

  a_busy_no_ack: assert property (s_dev_slot and (busy) |=> sda_oe_n && state == TW_IDLE)
    else $error("device word acknowledged during program cycle");

  a_wrong_addr: assert property (s_dev_slot and (!dev_match) |=> state == TW_IDLE)
    else $error("mismatching device word not ignored");

  a_page_wrap: assert property (s_page_byte |=> $stable(page_sel))
    else $error("write crossed a page boundary");

  a_wp_blocks: assert property (ce && stop_evt && wp_s && !busy |=> !busy)
    else $error("program cycle started while protected");

  a_prog_start: assert property (ce && prog_start && !busy |=> busy ##1 busy)
    else $error("program cycle did not start after stop");

  a_drive_low_clk: assert property ($fell(sda_oe_n) |-> !scl_s)
    else $error("data line driven while clock high");

  a_start_reset: assert property (ce && start_evt |=> state == TW_DEV && cnt == `TW_CNT_ZERO)
    else $error("start did not reset the byte slot");

  // A read ended by the host's missing acknowledge is already idle when the stop arrives.
  a_read_stop: assert property (ce && stop_evt && !busy
    && ((state == TW_RD) || (state == TW_IDLE)) |=> ##1 standby)
    else $error("stop after read did not enter standby");

  a_read_step: assert property (ce && rd_go |=> ctr == $past(ctr) + 1'b1)
    else $error("read did not advance the counter");

endmodule

/* verilog/tw_pkg.sv */
// Types shared by the two-wire serial memory target.
package tw_pkg;

  // --------------------------------------------------------------------------
  // Protocol states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TW_IDLE,
    TW_DEV,
    TW_WHI,
    TW_WLO,
    TW_WDATA,
    TW_RD
  } tw_state_t;

endpackage
